//--- design/btc_core.sv
// Sixteen-bit double-buffered timer/counter core with three compare channels.
module btc_core
   import btc_pkg::*;
(
   input  wire logic              sys_clk_i,               // Peripheral clock, 200 MHz.
   input  wire logic              rstn_i,                  // Asynchronous reset, active low.
   input  wire logic              enable_i,                // Counter enable level.
   input  wire logic [SEL_W-1:0]  prescaler_select_i,      // Clock division select.
   input  wire logic              event_count_input_enable_i, // Count events, not ticks.
   input  wire logic              event_i,                 // One-cycle count event.
   input  wire logic              count_down_i,            // Direction: 1 counts down.
   input  wire logic              update_lock_bit_i,       // Blocks buffer copies.
   input  wire logic [MODE_W-1:0] waveform_mode_field_i,   // Waveform mode code.
   input  wire logic [CH_N-1:0]   channel_output_enable_i, // Pin override per channel.
   input  wire logic [CH_N-1:0]   port_out_i,              // Port's own output values.
   input  wire logic [CNT_W-1:0]  wdata_i,                 // Write data for all strobes.
   input  wire logic              count_wr_i,              // Write strobe, count.
   input  wire logic              cycle_length_wr_i,       // Write strobe, working limit.
   input  wire logic              cycle_length_buffer_wr_i,// Write strobe, limit buffer.
   input  wire logic [CH_N-1:0]   match_value_wr_i,        // Write strobes, working compares.
   input  wire logic [CH_N-1:0]   match_value_buffer_wr_i, // Write strobes, compare buffers.
   input  wire logic [CH_N-1:0]   match_flag_clear_i,      // Clear strobes, match flags.
   input  wire logic [CH_N-1:0]   match_irq_enable_i,      // Interrupt enables per channel.
   output logic [CNT_W-1:0]       count_o,                 // Counter value.
   output logic [CNT_W-1:0]       cycle_length_o,          // Working cycle length.
   output logic [CNT_W-1:0]       cycle_length_buffer_o,   // Cycle length buffer.
   output logic                   cycle_length_valid_flag_o, // Limit buffer valid.
   output logic [CH_N*CNT_W-1:0]  match_value_o,           // Working compares, ch0 low.
   output logic [CH_N*CNT_W-1:0]  match_value_buffer_o,    // Compare buffers, ch0 low.
   output logic [CH_N-1:0]        match_valid_flag_o,      // Compare buffers valid.
   output logic [CH_N-1:0]        match_flag_o,            // Sticky match flags.
   output logic                   match_irq_o,             // Any enabled flag set.
   output logic                   zero_point_o,            // Pulse: zero reached.
   output logic                   upper_limit_o,           // Pulse: upper limit reached.
   output logic                   at_max_o,                // Counter is all ones.
   output logic [CH_N-1:0]        waveform_output_pin_o    // Pin values after override.
);

   // Prescaler mask lookup.
   function automatic logic [PRESC_W-1:0] presc_mask(input logic [SEL_W-1:0] sel);
      case (sel)
         3'h0:    presc_mask = DIV1_MASK;
         3'h1:    presc_mask = DIV2_MASK;
         3'h2:    presc_mask = DIV4_MASK;
         3'h3:    presc_mask = DIV8_MASK;
         3'h4:    presc_mask = DIV16_MASK;
         3'h5:    presc_mask = DIV64_MASK;
         3'h6:    presc_mask = DIV256_MASK;
         default: presc_mask = DIV1024_MASK;
      endcase
   endfunction

   logic [PRESC_W-1:0] presc_cnt;
   logic [CNT_W-1:0]   count;
   logic [CNT_W-1:0]   cycle_length;
   logic [CNT_W-1:0]   cycle_length_buffer;
   logic               cycle_length_valid_flag;
   logic [CNT_W-1:0]   match_value_reg    [0:CH_N-1];
   logic [CNT_W-1:0]   match_value_buffer [0:CH_N-1];
   logic [CH_N-1:0]    match_valid_flag;
   logic [CH_N-1:0]    match_flag;
   logic [CH_N-1:0]    wave;
   logic [CH_N-1:0]    pin_out;
   logic               zero_point;
   logic               upper_limit;

   // Tick selection: prescaled clock or event, both gated by enable.
   wire logic [PRESC_W-1:0] mask_w      = presc_mask(prescaler_select_i);
   wire logic              presc_tick_w = (presc_cnt & mask_w) == mask_w;
   wire logic              tick_w       = enable_i &
                                          (event_count_input_enable_i ? event_i
                                                                       : presc_tick_w);
   wire logic [PRESC_W-1:0] next_presc  = enable_i ? presc_cnt + 10'h001 : PRESC_RST;

   // Limit selection and counter state decode.
   wire logic              freq_mode_w  = waveform_mode_field_i == BTC_MODE_FREQ;
   wire logic              wave_mode_w  = waveform_mode_field_i != BTC_MODE_NORMAL;
   wire logic [CNT_W-1:0]  limit_w      = freq_mode_w ? match_value_reg[0]
                                                      : cycle_length;
   wire logic              is_zero_w    = count == ZERO_VAL;
   wire logic              is_max_w     = count == MAX_VAL;
   wire logic              is_limit_w   = count == limit_w;
   wire logic              dual_w       = waveform_mode_field_i == BTC_MODE_DSTOP  ||
                                          waveform_mode_field_i == BTC_MODE_DSBOTH ||
                                          waveform_mode_field_i == BTC_MODE_DSZERO;
   // Update at zero when counting down or in dual-slope modes, else at the limit.
   wire logic              upd_at_zero_w = count_down_i | dual_w;
   wire logic              update_w     = tick_w &
                                          (upd_at_zero_w ? is_zero_w : is_limit_w);
   wire logic              copy_w       = update_w & ~update_lock_bit_i;

   // Next count: a limit below the count leaves the counter running up to all ones,
   // so the only wrap points going up are the limit itself and the maximum.
   logic [CNT_W-1:0] next_count;
   always_comb begin
      next_count = count;
      if (tick_w) begin
         if (count_down_i) begin
            next_count = is_zero_w ? limit_w : count - ONE_VAL;
         end else begin
            next_count = (is_limit_w || is_max_w) ? ZERO_VAL : count + ONE_VAL;
         end
      end
      if (count_wr_i) begin
         next_count = wdata_i;
      end
   end

   // Compare hits, evaluated only on a timer tick.
   logic [CH_N-1:0] hit_w;
   always_comb begin
      for (int n = 0; n < CH_N; n++) begin
         hit_w[n] = tick_w & (count == match_value_reg[n]);
      end
   end

   // Prescaler and counter registers.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         presc_cnt <= PRESC_RST;
         count     <= ZERO_VAL;
      end else begin
         presc_cnt <= next_presc;
         count     <= next_count;
      end
   end

   // Cycle length and its buffer; a direct write beats a copy in the same cycle.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cycle_length            <= LIMIT_RST;
         cycle_length_buffer     <= LIMIT_RST;
         cycle_length_valid_flag <= 1'b0;
      end else begin
         if (cycle_length_wr_i) begin
            cycle_length <= wdata_i;
         end else if (copy_w && cycle_length_valid_flag) begin
            cycle_length <= cycle_length_buffer;
         end
         if (cycle_length_buffer_wr_i) begin
            cycle_length_buffer     <= wdata_i;
            cycle_length_valid_flag <= 1'b1;
         end else if (copy_w) begin
            cycle_length_valid_flag <= 1'b0;
         end
      end
   end

   // Compare registers and buffers; a buffer write in an update cycle keeps its flag.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int n = 0; n < CH_N; n++) begin
            match_value_reg[n]    <= MATCH_RST;
            match_value_buffer[n] <= MATCH_RST;
         end
         match_valid_flag <= '0;
      end else begin
         for (int n = 0; n < CH_N; n++) begin
            if (match_value_wr_i[n]) begin
               match_value_reg[n] <= wdata_i;
            end else if (copy_w && match_valid_flag[n]) begin
               match_value_reg[n] <= match_value_buffer[n];
            end
            if (match_value_buffer_wr_i[n]) begin
               match_value_buffer[n] <= wdata_i;
               match_valid_flag[n]   <= 1'b1;
            end else if (copy_w) begin
               match_valid_flag[n]   <= 1'b0;
            end
         end
      end
   end

   // Match flags, waveforms and event pulses land one cycle after the tick.
   // A hit that meets a clear in the same cycle keeps the flag set.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         match_flag  <= '0;
         wave        <= '0;
         zero_point  <= 1'b0;
         upper_limit <= 1'b0;
         pin_out     <= '0;
      end else begin
         match_flag  <= (match_flag & ~match_flag_clear_i) | hit_w;
         if (freq_mode_w) begin
            wave <= wave ^ hit_w;
         end
         zero_point  <= tick_w & is_zero_w;
         upper_limit <= tick_w & is_limit_w;
         for (int n = 0; n < CH_N; n++) begin
            pin_out[n] <= (wave_mode_w && channel_output_enable_i[n]) ? wave[n]
                                                                     : port_out_i[n];
         end
      end
   end

   // Output wiring.
   assign count_o                   = count;
   assign cycle_length_o            = cycle_length;
   assign cycle_length_buffer_o     = cycle_length_buffer;
   assign cycle_length_valid_flag_o = cycle_length_valid_flag;
   assign match_valid_flag_o        = match_valid_flag;
   assign match_flag_o              = match_flag;
   assign match_irq_o               = |(match_flag & match_irq_enable_i);
   assign zero_point_o              = zero_point;
   assign upper_limit_o             = upper_limit;
   assign at_max_o                  = is_max_w;
   assign waveform_output_pin_o     = pin_out;
   always_comb begin
      for (int n = 0; n < CH_N; n++) begin
         match_value_o[n*CNT_W +: CNT_W]        = match_value_reg[n];
         match_value_buffer_o[n*CNT_W +: CNT_W] = match_value_buffer[n];
      end
   end

   // Checks on the counting, buffering and compare behaviour.
   property p_hold_disabled;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (!enable_i && !count_wr_i) |=> (count == $past(count));
   endproperty
   a_hold_disabled: assert property (p_hold_disabled)
      else $error("Counter moved while disabled.");

   property p_write_wins;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      count_wr_i |=> (count == $past(wdata_i));
   endproperty
   a_write_wins: assert property (p_write_wins)
      else $error("Count write did not take effect.");

   property p_wrap_up;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (tick_w && !count_down_i && is_limit_w && !count_wr_i) |=> (count == ZERO_VAL);
   endproperty
   a_wrap_up: assert property (p_wrap_up)
      else $error("Counter did not wrap to zero at the limit.");

   property p_reload_down;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (tick_w && count_down_i && is_zero_w && !count_wr_i) |=> (count == $past(limit_w));
   endproperty
   a_reload_down: assert property (p_reload_down)
      else $error("Counter did not reload at zero.");

   property p_step_up;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (tick_w && !count_down_i && !is_limit_w && !is_max_w && !count_wr_i)
         |=> (count == $past(count) + ONE_VAL);
   endproperty
   a_step_up: assert property (p_step_up)
      else $error("Counter did not step up.");

   property p_copy_limit;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (copy_w && cycle_length_valid_flag && !cycle_length_wr_i)
         |=> (cycle_length == $past(cycle_length_buffer)) && !cycle_length_valid_flag
             || $past(cycle_length_buffer_wr_i);
   endproperty
   a_copy_limit: assert property (p_copy_limit)
      else $error("Cycle length buffer was not copied on update.");

   property p_lock_blocks;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (update_lock_bit_i && !cycle_length_wr_i) |=> $stable(cycle_length);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks)
      else $error("Cycle length changed under update lock.");

   property p_buf_valid;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      match_value_buffer_wr_i[0] |=> match_valid_flag[0] ##0
         (match_value_buffer[0] == $past(wdata_i));
   endproperty
   a_buf_valid: assert property (p_buf_valid)
      else $error("Compare buffer write did not set its valid flag.");

   property p_match_flag;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      hit_w[1] |=> match_flag[1];
   endproperty
   a_match_flag: assert property (p_match_flag)
      else $error("Compare match did not set the flag.");

   property p_freq_toggle;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (freq_mode_w && hit_w[0]) |=> (wave[0] != $past(wave[0]));
   endproperty
   a_freq_toggle: assert property (p_freq_toggle)
      else $error("Frequency output did not toggle on match.");

   property p_override;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (wave_mode_w && channel_output_enable_i[2]) |=> (pin_out[2] == $past(wave[2]));
   endproperty
   a_override: assert property (p_override)
      else $error("Pin was not overridden by the waveform.");

   property p_cycle_write;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      cycle_length_wr_i |=> (cycle_length == $past(wdata_i));
   endproperty
   a_cycle_write: assert property (p_cycle_write)
      else $error("Cycle length write did not take effect at once.");

   property p_event_hold;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (enable_i && event_count_input_enable_i && !event_i && !count_wr_i) |=> $stable(count);
   endproperty
   a_event_hold: assert property (p_event_hold)
      else $error("Counter moved without an event in event mode.");

   property p_valid_clear;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (copy_w && !cycle_length_buffer_wr_i) |=> !cycle_length_valid_flag;
   endproperty
   a_valid_clear: assert property (p_valid_clear)
      else $error("Cycle length valid flag survived the update.");

   property p_flag_clear;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (match_flag_clear_i[0] && !hit_w[0]) |=> !match_flag[0];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("Match flag was not cleared.");

endmodule : btc_core

//--- design/btc_pkg.sv
// Shared constants and types for the buffered timer/counter core.
package btc_pkg;
   localparam int          CNT_W     = 16;             // Counter and compare width.
   localparam int          CH_N      = 3;              // Number of compare channels.
   localparam int          PRESC_W   = 10;             // Prescaler counter width.
   localparam int          SEL_W     = 3;              // Prescaler select width.
   localparam int          MODE_W    = 3;              // Waveform mode field width.
   localparam logic [15:0] ZERO_VAL  = 16'h0000;       // Zero point value.
   localparam logic [15:0] MAX_VAL   = 16'hFFFF;       // All ones.
   localparam logic [15:0] ONE_VAL   = 16'h0001;       // Count step.
   localparam logic [15:0] LIMIT_RST = 16'hFFFF;       // Reset value of the cycle length.
   localparam logic [15:0] MATCH_RST = 16'h0000;       // Reset value of compare registers.
   localparam logic [9:0]  PRESC_RST = 10'h000;        // Reset value of prescaler counter.

   // Prescaler division masks: divide by 1, 2, 4, 8, 16, 64, 256, 1024.
   localparam logic [9:0]  DIV1_MASK    = 10'h000;
   localparam logic [9:0]  DIV2_MASK    = 10'h001;
   localparam logic [9:0]  DIV4_MASK    = 10'h003;
   localparam logic [9:0]  DIV8_MASK    = 10'h007;
   localparam logic [9:0]  DIV16_MASK   = 10'h00F;
   localparam logic [9:0]  DIV64_MASK   = 10'h03F;
   localparam logic [9:0]  DIV256_MASK  = 10'h0FF;
   localparam logic [9:0]  DIV1024_MASK = 10'h3FF;

   // Waveform mode field codes.
   typedef enum logic [2:0] {
      BTC_MODE_NORMAL  = 3'h0,
      BTC_MODE_FREQ    = 3'h1,
      BTC_MODE_SSPWM   = 3'h3,
      BTC_MODE_DSTOP   = 3'h5,
      BTC_MODE_DSBOTH  = 3'h6,
      BTC_MODE_DSZERO  = 3'h7
   } btc_mode_t;
endpackage : btc_pkg

//--- tb/btc_pin_model.sv
// Pin-side partner: supplies the port's own output values and watches the waveform pins.
module btc_pin_model (
   input  wire logic        sys_clk_i,  // Peripheral clock.
   input  wire logic        rstn_i,     // Asynchronous reset, active low.
   input  wire logic [2:0]  pin_i,      // Pin values after override.
   input  wire logic [2:0]  port_val_i, // Value software keeps in the port.
   output logic [2:0]       port_out_o, // Port output value offered to the timer.
   output logic [15:0]      edges_o     // Level changes seen on pin 0.
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] last_pin;
   // The port register passes its value straight on; the timer decides on override.
   assign port_out_o = port_val_i;
   // Counting edges rather than sampling levels makes the toggle rate checkable.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_pin <= 3'h0;
         edges_o  <= 16'h0000;
      end else begin
         last_pin <= pin_i;
         if (pin_i[0] !== last_pin[0]) begin
            edges_o <= edges_o + 16'h0001;
         end
      end
   end
endmodule // btc_pin_model

//--- tb/tb.sv
// Self-checking bench for the buffered timer/counter core.
module tb
   import btc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [2:0] sel; logic dn; logic [15:0] lim; logic [15:0] start;
      logic [11:0] n; logic [15:0] exp;
   } btc_row_t;
   logic        sys_clk_i, rstn_i, en, evt_en, evt, dn, lock, cnt_wr, cl_wr, clb_wr;
   logic [2:0]  sel, mode, oe, mv_wr, mvb_wr, fclr, irq_en, port_val, port_out, mvv, mf, pins;
   logic [15:0] wd, cnt, cl, clb, edges;
   logic [47:0] mv, mvb;
   logic        clv, irq, zp, ul, amax;
   int          miscompares, samples_checked;
   // Prescaler codes, wrap, reload and late limit cases; each row starts from a stopped counter.
   btc_row_t rows [11] = '{
      '{3'h0, 1'b0, 16'hFFFF, 16'h0000, 12'h002, 16'h0002},
      '{3'h1, 1'b0, 16'hFFFF, 16'h0000, 12'h004, 16'h0002},
      '{3'h2, 1'b0, 16'hFFFF, 16'h0000, 12'h008, 16'h0002},
      '{3'h3, 1'b0, 16'hFFFF, 16'h0000, 12'h010, 16'h0002},
      '{3'h4, 1'b0, 16'hFFFF, 16'h0000, 12'h020, 16'h0002},
      '{3'h5, 1'b0, 16'hFFFF, 16'h0000, 12'h080, 16'h0002},
      '{3'h6, 1'b0, 16'hFFFF, 16'h0000, 12'h200, 16'h0002},
      '{3'h7, 1'b0, 16'hFFFF, 16'h0000, 12'h800, 16'h0002},
      '{3'h0, 1'b0, 16'h0003, 16'h0000, 12'h004, 16'h0000},
      '{3'h0, 1'b1, 16'h0005, 16'h0001, 12'h003, 16'h0004},
      '{3'h0, 1'b0, 16'h0005, 16'hFFFD, 12'h003, 16'h0000}};
   btc_core u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .enable_i(en),
      .prescaler_select_i(sel), .event_count_input_enable_i(evt_en), .event_i(evt),
      .count_down_i(dn), .update_lock_bit_i(lock), .waveform_mode_field_i(mode),
      .channel_output_enable_i(oe), .port_out_i(port_out), .wdata_i(wd), .count_wr_i(cnt_wr),
      .cycle_length_wr_i(cl_wr), .cycle_length_buffer_wr_i(clb_wr), .match_value_wr_i(mv_wr),
      .match_value_buffer_wr_i(mvb_wr), .match_flag_clear_i(fclr),
      .match_irq_enable_i(irq_en), .count_o(cnt), .cycle_length_o(cl),
      .cycle_length_buffer_o(clb), .cycle_length_valid_flag_o(clv), .match_value_o(mv),
      .match_value_buffer_o(mvb), .match_valid_flag_o(mvv), .match_flag_o(mf),
      .match_irq_o(irq), .zero_point_o(zp), .upper_limit_o(ul), .at_max_o(amax),
      .waveform_output_pin_o(pins));
   btc_pin_model u_pins (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .pin_i(pins),
      .port_val_i(port_val), .port_out_o(port_out), .edges_o(edges));
   // Free-running 200 MHz clock.
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   // Compares are counted even when they match, so an empty run cannot pass.
   task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
      samples_checked++;
   endtask
   // One write strobe for one cycle: 0 count, 1 limit, 2 limit buffer, 3..5 compares, 6..8 buffers.
   task automatic put(input int which, input logic [15:0] d);
      @(negedge sys_clk_i);
      wd = d;
      case (which)
         0: cnt_wr = 1'b1;
         1: cl_wr = 1'b1;
         2: clb_wr = 1'b1;
         3, 4, 5: mv_wr[which-3] = 1'b1;
         default: mvb_wr[which-6] = 1'b1;
      endcase
      @(negedge sys_clk_i);
      {cnt_wr, cl_wr, clb_wr, mv_wr, mvb_wr} = '0;
   endtask
   // Enable for exactly n rising edges; the prescaler restarts each time.
   task automatic run(input int n);
      @(negedge sys_clk_i);
      en = 1'b1;
      repeat (n) @(negedge sys_clk_i);
      en = 1'b0;
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // The longest row needs about 2000 cycles; the whole run stays well under this span.
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      miscompares++;
      report_and_stop();
   end
   // Main sequence.
   initial begin
      {en, evt_en, evt, dn, lock, cnt_wr, cl_wr, clb_wr, sel, mode, oe} = '0;
      {mv_wr, mvb_wr, fclr, irq_en, wd} = '0;
      port_val = 3'h6;
      miscompares = 0;
      samples_checked = 0;
      rstn_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      chk("count", cnt, 16'h0000);
      chk("limit", cl, LIMIT_RST);
      chk("flags", {clv, mvv, mf}, 7'h00);
      foreach (rows[i]) begin
         put(0, rows[i].start);
         put(1, rows[i].lim);
         sel = rows[i].sel;
         dn = rows[i].dn;
         run(int'(rows[i].n));
         chk("row count", cnt, rows[i].exp);
         repeat (3) @(negedge sys_clk_i);
         chk("held count", cnt, rows[i].exp);
      end
      // A count write in a tick cycle wins over the increment, then direction flips.
      put(1, 16'hFFFF);
      put(0, 16'h0010);
      @(negedge sys_clk_i);
      en = 1'b1;
      @(negedge sys_clk_i);
      wd = 16'h1234;
      cnt_wr = 1'b1;
      @(negedge sys_clk_i);
      cnt_wr = 1'b0;
      en = 1'b0;
      chk("count write", cnt, 16'h1234);
      dn = 1'b1;
      run(2);
      chk("down count", cnt, 16'h1232);
      // Event counting ignores the idle cycles between pulses.
      dn = 1'b0;
      evt_en = 1'b1;
      @(negedge sys_clk_i);
      en = 1'b1;
      repeat (3) begin
         evt = 1'b1;
         @(negedge sys_clk_i);
         evt = 1'b0;
         @(negedge sys_clk_i);
      end
      en = 1'b0;
      evt_en = 1'b0;
      chk("event count", cnt, 16'h1235);
      // Buffered limit: held off by the lock, copied at the next limit once released.
      put(0, 16'h0000);
      put(1, 16'h0003);
      put(2, 16'h0007);
      chk("limit valid", {clv, cl, clb}, {1'b1, 16'h0003, 16'h0007});
      lock = 1'b1;
      run(4);
      chk("locked limit", {clv, cl}, {1'b1, 16'h0003});
      lock = 1'b0;
      run(3);
      run(1);
      chk("limit copy", {cnt, cl, clv, ul}, {16'h0000, 16'h0007, 2'b01});
      @(negedge sys_clk_i);
      chk("limit pulse", ul, 1'b0);
      // Compare channel 0 written directly, channel 1 through its buffer.
      // Channels 1 and 2 still compare against zero, and only channel 0 may interrupt.
      put(3, 16'h0002);
      irq_en = 3'h1;
      fclr = 3'h7;
      @(negedge sys_clk_i);
      fclr = 3'h0;
      run(2);
      chk("no match yet", {mf, irq}, 4'hC);
      run(1);
      chk("match", {mf, irq}, 4'hF);
      @(negedge sys_clk_i);
      fclr = 3'h7;
      @(negedge sys_clk_i);
      fclr = 3'h0;
      chk("cleared", {mf, irq}, 4'h0);
      put(7, 16'h0005);
      chk("cmp buffer", {mvv, mvb[31:16], mv[31:16]}, {3'h2, 16'h0005, 16'h0000});
      run(5);
      chk("cmp copy", {mvv, mv[31:16]}, {3'h0, 16'h0005});
      run(6);
      chk("cmp1 match", mf[1], 1'b1);
      // Toggle mode: limit taken from compare 0 and pin 0 toggles at each match.
      mode = 3'h1;
      oe = 3'h5;
      put(3, 16'h0001);
      put(0, 16'h0000);
      run(20);
      repeat (3) @(negedge sys_clk_i);
      chk("toggle", {cnt, edges}, {16'h0000, 16'h000A});
      chk("port pins", pins[2:1], 2'b01);
      oe = 3'h0;
      port_val = 3'h7;
      repeat (3) @(negedge sys_clk_i);
      chk("released", pins, port_val);
      // Down count through zero reloads and marks the zero point.
      mode = 3'h0;
      dn = 1'b1;
      put(0, 16'h0001);
      run(2);
      chk("reload", {cnt, zp}, {16'h0007, 1'b1});
      put(0, 16'hFFFF);
      chk("at max", amax, 1'b1);
      // A reset in mid-run puts the counter and the limit back to their idle values.
      rstn_i = 1'b0;
      @(negedge sys_clk_i);
      rstn_i = 1'b1;
      chk("reset", {cnt, cl, amax}, {16'h0000, LIMIT_RST, 1'b0});
      report_and_stop();
   end
endmodule // tb
